// ===== rtl/dmu_pkg.sv
package dmu_pkg;

	// ----------------------------------------------------------------
	// Operand layout
	// ----------------------------------------------------------------
	localparam int unsigned GPR_W = 64;
	localparam int unsigned TYPE_W = 5;
	// Bits 32:36 in MSB-0 numbering of a 64-bit register
	localparam int unsigned TYPE_LSB = 27;
	localparam logic [63:0] TYPE_FIELD_MASK = 64'h0000_0000_F800_0000;

	// ----------------------------------------------------------------
	// Message types and doorbell classes
	// ----------------------------------------------------------------
	localparam int unsigned NUM_DB = 5;
	localparam logic [4:0] NUM_BASE_TYPES = 5'h02;
	localparam logic [4:0] NUM_HV_TYPES = 5'h05;
	localparam int unsigned DB_NORMAL = 0;
	localparam int unsigned DB_CRIT = 1;
	localparam int unsigned DB_GUEST = 2;
	localparam int unsigned DB_GUEST_CRIT = 3;
	localparam int unsigned DB_GUEST_MC = 4;

	// ----------------------------------------------------------------
	// Interconnect transaction types
	// ----------------------------------------------------------------
	localparam logic [1:0] TT_NONE = 2'h0;
	localparam logic [1:0] TT_READ = 2'h1;
	localparam logic [1:0] TT_WRITE = 2'h2;
	localparam logic [1:0] TT_MSG = 2'h3;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		DMU_IDLE = 2'b00,
		DMU_HOLD = 2'b01,
		DMU_ISSUE = 2'b10
	} dmu_tx_state_e;

	typedef struct packed {
		dmu_tx_state_e state;
		logic send_ready;
		logic tx_valid;
		logic [1:0] tx_ttype;
		logic [GPR_W-1:0] tx_data;
		logic hold;
		logic [NUM_DB-1:0] pend;
		logic [NUM_DB-1:0] irq_req;
	} dmu_state_s;

	localparam logic [NUM_DB-1:0] PEND_RST = 5'h00;
	localparam logic [GPR_W-1:0] DATA_RST = 64'h0000_0000_0000_0000;
	localparam dmu_state_s STATE_RST = '{
		state: DMU_IDLE,
		send_ready: 1'b0,
		tx_valid: 1'b0,
		tx_ttype: TT_NONE,
		tx_data: DATA_RST,
		hold: 1'b0,
		pend: PEND_RST,
		irq_req: PEND_RST
	};

endpackage : dmu_pkg

// ===== rtl/dmu_filter.sv
`timescale 1ns/1ps
`default_nettype none

module dmu_filter
	import dmu_pkg::*;
#(
	parameter bit HV_IMPL = 1'b1,
	parameter logic [GPR_W-1:0] PAYLOAD_MASK = 64'h0000_0000_0000_0000,
	parameter logic [GPR_W-1:0] PAYLOAD_MATCH = 64'h0000_0000_0000_0000
) (
	input wire logic msg_valid,
	input wire logic [1:0] msg_ttype,
	input wire logic [GPR_W-1:0] msg_data,
	output logic [NUM_DB-1:0] accept,
	output logic msg_seen,
	output logic supported
);

	// ----------------------------------------------------------------
	// Type and payload checks
	// ----------------------------------------------------------------
	logic [TYPE_W-1:0] msg_type;
	logic [GPR_W-1:0] cmp_mask;
	logic payload_ok;
	logic [TYPE_W-1:0] type_limit;

	assign msg_type = msg_data[TYPE_LSB +: TYPE_W];
	// Type bits never take part in the payload compare
	assign cmp_mask = PAYLOAD_MASK & ~TYPE_FIELD_MASK;
	assign payload_ok = ((msg_data ^ PAYLOAD_MATCH) & cmp_mask) == DATA_RST;
	assign type_limit = HV_IMPL ? NUM_HV_TYPES : NUM_BASE_TYPES;
	assign msg_seen = msg_valid && (msg_ttype == TT_MSG);
	assign supported = msg_type < type_limit;

	genvar i;
	generate
		for (i = 0; i < NUM_DB; i++) begin : g_acc
			assign accept[i] = msg_seen && supported && payload_ok
				&& (msg_type == TYPE_W'(i));
		end
	endgenerate

endmodule : dmu_filter

`default_nettype wire

// ===== rtl/dmu_unit.sv
`timescale 1ns/1ps
`default_nettype none

module dmu_unit
	import dmu_pkg::*;
#(
	parameter bit HYPERVISOR_CATEGORY = 1'b1,
	parameter logic [GPR_W-1:0] PAYLOAD_MASK = 64'h0000_0000_0000_0000,
	parameter logic [GPR_W-1:0] PAYLOAD_MATCH = 64'h0000_0000_0000_0000
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic send_valid,
	input wire logic [GPR_W-1:0] send_operand,
	output logic send_ready,
	input wire logic barrier_req,
	input wire logic stores_drained,
	output logic tx_valid,
	output logic [1:0] tx_ttype,
	output logic [GPR_W-1:0] tx_data,
	input wire logic tx_ready,
	input wire logic rx_valid,
	input wire logic [1:0] rx_ttype,
	input wire logic [GPR_W-1:0] rx_data,
	input wire logic clear_valid,
	input wire logic [GPR_W-1:0] clear_operand,
	input wire logic external_irq_enable,
	input wire logic critical_irq_enable,
	input wire logic machine_check_enable,
	input wire logic guest_state,
	input wire logic [NUM_DB-1:0] irq_taken,
	output logic [NUM_DB-1:0] irq_req,
	output logic [NUM_DB-1:0] pending
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	dmu_state_s s_q;
	dmu_state_s s_d;
	logic [NUM_DB-1:0] accept;
	logic rx_msg;
	logic rx_supported;
	logic [NUM_DB-1:0] gate;
	logic [NUM_DB-1:0] clr_hit;
	logic [NUM_DB-1:0] pend_nx;
	logic [TYPE_W-1:0] clear_type;
	logic send_fire;

	// ----------------------------------------------------------------
	// Receive filter
	// ----------------------------------------------------------------
	// The receive port has no ready: a broadcast is never back-pressured
	// and every beat is looked at, including our own loopback copy.
	dmu_filter #(
		.HV_IMPL(HYPERVISOR_CATEGORY),
		.PAYLOAD_MASK(PAYLOAD_MASK),
		.PAYLOAD_MATCH(PAYLOAD_MATCH)
	) u_filter (
		.msg_valid(rx_valid),
		.msg_ttype(rx_ttype),
		.msg_data(rx_data),
		.accept(accept),
		.msg_seen(rx_msg),
		.supported(rx_supported)
	);

	// ----------------------------------------------------------------
	// Delivery gating
	// ----------------------------------------------------------------
	assign gate[DB_NORMAL] = external_irq_enable;
	assign gate[DB_CRIT] = critical_irq_enable;
	assign gate[DB_GUEST] = external_irq_enable & guest_state;
	assign gate[DB_GUEST_CRIT] = critical_irq_enable & guest_state;
	assign gate[DB_GUEST_MC] = machine_check_enable & guest_state;

	// ----------------------------------------------------------------
	// Pending flags
	// ----------------------------------------------------------------
	assign clear_type = clear_operand[TYPE_LSB +: TYPE_W];

	// A fresh accept in the same cycle as a take or clear keeps the flag
	// set, so that event is not lost; a repeat accept on a set flag is
	// absorbed because the flag is a single bit.
	genvar i;
	generate
		for (i = 0; i < NUM_DB; i++) begin : g_db
			assign clr_hit[i] = clear_valid
				&& (clear_type == TYPE_W'(i));
			assign pend_nx[i] = accept[i]
				| (s_q.pend[i] & ~clr_hit[i] & ~irq_taken[i]);

			sequence s_gated_wait;
				s_q.pend[i] && !gate[i] && !clr_hit[i]
				&& !irq_taken[i]
				##1 gate[i] && !clr_hit[i] && !irq_taken[i];
			endsequence

			property p_set;
				@(posedge ref_clk) disable iff (!resetn)
				accept[i] |=> pending[i];
			endproperty
			a_set: assert property (p_set)
				else $error("accepted doorbell did not pend");

			property p_keep;
				@(posedge ref_clk) disable iff (!resetn)
				pending[i] && !clr_hit[i] && !irq_taken[i] |=> pending[i];
			endproperty
			a_keep: assert property (p_keep)
				else $error("pending doorbell dropped without cause");

			property p_clear;
				@(posedge ref_clk) disable iff (!resetn)
				(clr_hit[i] || irq_taken[i]) && !accept[i] |=> !pending[i];
			endproperty
			a_clear: assert property (p_clear)
				else $error("doorbell not cleared by take or clear");

			property p_gate;
				@(posedge ref_clk) disable iff (!resetn)
				irq_req[i] |-> $past(gate[i]) && $past(pend_nx[i]);
			endproperty
			a_gate: assert property (p_gate)
				else $error("doorbell requested while gated off");

			property p_pended;
				@(posedge ref_clk) disable iff (!resetn)
				s_gated_wait |=> irq_req[i] && pending[i];
			endproperty
			a_pended: assert property (p_pended)
				else $error("pended doorbell not raised on enable");

			property p_no_req;
				@(posedge ref_clk) disable iff (!resetn)
				!pending[i] |-> !irq_req[i];
			endproperty
			a_no_req: assert property (p_no_req)
				else $error("doorbell request without pending flag");

			property p_req_off;
				@(posedge ref_clk) disable iff (!resetn)
				!gate[i] |=> !irq_req[i];
			endproperty
			a_req_off: assert property (p_req_off)
				else $error("doorbell request while its enable was low");

			property p_req_on;
				@(posedge ref_clk) disable iff (!resetn)
				pend_nx[i] && gate[i] |=> irq_req[i];
			endproperty
			a_req_on: assert property (p_req_on)
				else $error("enabled pending doorbell not requested");

			property p_type_decode;
				@(posedge ref_clk) disable iff (!resetn)
				accept[i] |-> rx_msg
					&& (rx_data[TYPE_LSB +: TYPE_W] == TYPE_W'(i));
			endproperty
			a_type_decode: assert property (p_type_decode)
				else $error("accept on a class other than the message type");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Send path
	// ----------------------------------------------------------------
	assign send_fire = send_valid & s_q.send_ready;

	always_comb begin
		s_d = s_q;
		// A barrier in the same cycle as a send counts as older than it
		s_d.hold = barrier_req | (s_q.hold & ~stores_drained);
		s_d.pend = pend_nx;
		s_d.irq_req = pend_nx & gate;
		case (s_q.state)
			DMU_IDLE: begin
				s_d.send_ready = 1'b1;
				if (send_fire) begin
					// Operand goes out whole, type bits included
					s_d.tx_data = send_operand;
					s_d.tx_ttype = TT_MSG;
					s_d.send_ready = 1'b0;
					if (s_d.hold) begin
						s_d.state = DMU_HOLD;
					end else begin
						s_d.state = DMU_ISSUE;
						s_d.tx_valid = 1'b1;
					end
				end
			end
			DMU_HOLD: begin
				if (!s_d.hold) begin
					s_d.state = DMU_ISSUE;
					s_d.tx_valid = 1'b1;
				end
			end
			DMU_ISSUE: begin
				// No timeout: the interconnect may take any finite time
				if (tx_ready) begin
					s_d.state = DMU_IDLE;
					s_d.tx_valid = 1'b0;
					s_d.tx_ttype = TT_NONE;
					s_d.send_ready = 1'b1;
				end
			end
			default: begin
				s_d = STATE_RST;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= STATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign send_ready = s_q.send_ready;
	assign tx_valid = s_q.tx_valid;
	assign tx_ttype = s_q.tx_ttype;
	assign tx_data = s_q.tx_data;
	assign irq_req = s_q.irq_req;
	assign pending = s_q.pend;

	// ----------------------------------------------------------------
	// Send path and receive filter checks
	// ----------------------------------------------------------------
	sequence s_clean_send;
		send_valid && send_ready && !barrier_req
		&& (!s_q.hold || stores_drained);
	endsequence

	property p_send_issue;
		@(posedge ref_clk) disable iff (!resetn)
		s_clean_send |=> tx_valid && (tx_data == $past(send_operand));
	endproperty
	a_send_issue: assert property (p_send_issue)
		else $error("send not issued next cycle with its operand");

	property p_ttype;
		@(posedge ref_clk) disable iff (!resetn)
		tx_valid |-> tx_ttype == TT_MSG;
	endproperty
	a_ttype: assert property (p_ttype)
		else $error("message beat with wrong transaction type");

	property p_tx_stable;
		@(posedge ref_clk) disable iff (!resetn)
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
	endproperty
	a_tx_stable: assert property (p_tx_stable)
		else $error("message withdrawn before interconnect took it");

	property p_barrier;
		@(posedge ref_clk) disable iff (!resetn)
		$rose(tx_valid) |->
			$past(!barrier_req && (!s_q.hold || stores_drained));
	endproperty
	a_barrier: assert property (p_barrier)
		else $error("message issued ahead of barrier drain");

	property p_drop_bad;
		@(posedge ref_clk) disable iff (!resetn)
		rx_msg && !rx_supported && !clear_valid && (irq_taken == PEND_RST)
		|=> $stable(pending);
	endproperty
	a_drop_bad: assert property (p_drop_bad)
		else $error("unsupported message type changed pending flags");

	property p_accept_one;
		@(posedge ref_clk) disable iff (!resetn)
		accept != PEND_RST |-> $onehot0(accept) && rx_msg;
	endproperty
	a_accept_one: assert property (p_accept_one)
		else $error("accept without a message or on several types");

	property p_ready_busy;
		@(posedge ref_clk) disable iff (!resetn)
		send_fire |=> !send_ready ##1 (!send_ready || !tx_valid);
	endproperty
	a_ready_busy: assert property (p_ready_busy)
		else $error("send port reopened before message left");

	property p_no_phantom;
		@(posedge ref_clk) disable iff (!resetn)
		!rx_msg |-> accept == PEND_RST;
	endproperty
	a_no_phantom: assert property (p_no_phantom)
		else $error("accept without a message beat");

	property p_hold_quiet;
		@(posedge ref_clk) disable iff (!resetn)
		s_q.state == DMU_HOLD |-> !tx_valid && !send_ready;
	endproperty
	a_hold_quiet: assert property (p_hold_quiet)
		else $error("held message visible before drain");

	property p_hold_keep;
		@(posedge ref_clk) disable iff (!resetn)
		s_q.state == DMU_HOLD && (barrier_req || !stores_drained)
		|=> s_q.state == DMU_HOLD;
	endproperty
	a_hold_keep: assert property (p_hold_keep)
		else $error("held message released before stores drained");

	property p_hold_release;
		@(posedge ref_clk) disable iff (!resetn)
		s_q.state == DMU_HOLD && !barrier_req && stores_drained
		|=> tx_valid && tx_ttype == TT_MSG;
	endproperty
	a_hold_release: assert property (p_hold_release)
		else $error("held message not issued after drain");

	property p_issue_done;
		@(posedge ref_clk) disable iff (!resetn)
		tx_valid && tx_ready |=> !tx_valid && send_ready;
	endproperty
	a_issue_done: assert property (p_issue_done)
		else $error("message beat kept after interconnect took it");

	property p_tx_idle_type;
		@(posedge ref_clk) disable iff (!resetn)
		!tx_valid && s_q.state != DMU_HOLD |-> tx_ttype == TT_NONE;
	endproperty
	a_tx_idle_type: assert property (p_tx_idle_type)
		else $error("idle transmit port shows a message type");

endmodule : dmu_unit

`default_nettype wire

// ===== bench/dmu_xbar_model.sv
`timescale 1ns/1ps
`default_nettype none

module dmu_xbar_model
	import dmu_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [3:0] lat,
	input wire logic tx_valid,
	input wire logic [GPR_W-1:0] tx_data,
	output logic tx_ready,
	input wire logic inj_valid,
	input wire logic [1:0] inj_ttype,
	input wire logic [GPR_W-1:0] inj_data,
	output logic rx_valid,
	output logic [1:0] rx_ttype,
	output logic [GPR_W-1:0] rx_data
);
	logic lb_v = 1'b0;
	logic rdy = 1'b0;
	logic [GPR_W-1:0] lb_d = DATA_RST;
	logic [GPR_W-1:0] last_d = DATA_RST;
	logic [1:0] last_t = TT_NONE;

	// ----------------------------------------------------------------
	// Receive side
	// ----------------------------------------------------------------
	// Idle bus shows the inverse of the last beat, never a stale copy
	assign rx_valid = inj_valid | lb_v;
	assign rx_ttype = inj_valid ? inj_ttype : (lb_v ? TT_MSG : ~last_t);
	assign rx_data = inj_valid ? inj_data : (lb_v ? lb_d : ~last_d);
	always @(posedge ref_clk) begin
		if (rx_valid) begin
			last_t <= rx_ttype;
			last_d <= rx_data;
		end
	end

	// ----------------------------------------------------------------
	// Transmit side with loopback to the sender
	// ----------------------------------------------------------------
	assign tx_ready = rdy;
	always begin
		@(posedge ref_clk);
		if (resetn && tx_valid) begin
			repeat (lat) @(posedge ref_clk);
			rdy <= 1'b1;
			@(posedge ref_clk);
			lb_d <= tx_data;
			rdy <= 1'b0;
			repeat (lat) @(posedge ref_clk);
			lb_v <= 1'b1;
			@(posedge ref_clk);
			lb_v <= 1'b0;
		end
	end
endmodule : dmu_xbar_model

`default_nettype wire

// ===== bench/doorbell_message_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none

module doorbell_message_unit_tb
	import dmu_pkg::*;
;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic send_valid, barrier_req, stores_drained, clear_valid, inj_valid;
	logic external_irq_enable, critical_irq_enable;
	logic machine_check_enable, guest_state;
	logic [GPR_W-1:0] send_operand, clear_operand, inj_data, tx_data, rx_data;
	logic [1:0] inj_ttype, tx_ttype, rx_ttype;
	logic [NUM_DB-1:0] irq_taken, irq_req, pending;
	logic send_ready, tx_valid, tx_ready, rx_valid;
	logic [3:0] lat;
	logic [3:0] tbl [5] = '{4'h8, 4'h4, 4'h9, 4'h5, 4'h3};
	int fails = 0;
	int cmp_count = 0;

	always #20 ref_clk = ~ref_clk;

	dmu_unit #(.HYPERVISOR_CATEGORY(1'b1),
		.PAYLOAD_MASK(64'h0000_0000_0000_00FF),
		.PAYLOAD_MATCH(64'h0000_0000_0000_005A)) i_dut (.ref_clk, .resetn,
		.send_valid, .send_operand, .send_ready, .barrier_req,
		.stores_drained, .tx_valid, .tx_ttype, .tx_data, .tx_ready,
		.rx_valid, .rx_ttype, .rx_data, .clear_valid, .clear_operand,
		.external_irq_enable, .critical_irq_enable, .machine_check_enable,
		.guest_state, .irq_taken, .irq_req, .pending);
	dmu_xbar_model i_xbar (.ref_clk, .resetn, .lat, .tx_valid, .tx_data,
		.tx_ready, .inj_valid, .inj_ttype, .inj_data, .rx_valid, .rx_ttype,
		.rx_data);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [63:0] msg(input int t, input logic [7:0] pl);
		msg = (64'(t) << TYPE_LSB) | 64'(pl);
	endfunction : msg
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cyc
	task automatic gates(input logic [3:0] g);
		{external_irq_enable, critical_irq_enable} = g[3:2];
		{machine_check_enable, guest_state} = g[1:0];
	endtask : gates
	task automatic inject(input logic [1:0] tt, input logic [63:0] d);
		inj_ttype = tt;
		inj_data = d;
		inj_valid = 1'b1;
		cyc(1);
		inj_valid = 1'b0;
		// Idle cycle so back-to-back calls never drive valid twice at once
		cyc(1);
	endtask : inject
	task automatic clr(input int t);
		clear_operand = msg(t, 8'h00);
		clear_valid = 1'b1;
		cyc(1);
		clear_valid = 1'b0;
	endtask : clr
	// Bounded waits: delivery delay is not fixed
	task automatic wait_tx();
		for (int i = 0; i < 40 && tx_valid !== 1'b1; i++) cyc(1);
	endtask : wait_tx
	task automatic wait_pend(input int t);
		for (int i = 0; i < 40 && pending[t] !== 1'b1; i++) cyc(1);
	endtask : wait_pend

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_send();
		logic [63:0] op;
		for (int k = 0; k < 2; k++) begin
			lat = k ? 4'h5 : 4'h0;
			gates(4'h8);
			op = msg(0, 8'h5A) | 64'hA5A5_0000_0000_0000;
			chk("send_ready idle", 64'h1, 64'(send_ready));
			send_operand = op;
			send_valid = 1'b1;
			wait_tx();
			send_valid = 1'b0;
			chk("send_ready busy", 64'h0, 64'(send_ready));
			chk("tx_ttype", 64'(TT_MSG), 64'(tx_ttype));
			chk("tx_data", op, tx_data);
			wait_pend(0);
			chk("own pending", 64'h1, 64'(pending));
			chk("irq_req", 64'h1, 64'(irq_req));
			irq_taken = 5'h01;
			cyc(1);
			irq_taken = 5'h00;
			chk("pending taken", 64'h0, 64'(pending));
		end
		$display("test send done");
	endtask : t_send

	task automatic t_types();
		for (int t = 0; t < 5; t++) begin
			gates(4'h0);
			inject(TT_MSG, msg(t, 8'h5A));
			chk("pending", 64'(5'h01 << t), 64'(pending));
			chk("irq_req gated", 64'h0, 64'(irq_req));
			gates(~tbl[t]);
			cyc(1);
			chk("irq_req others", 64'h0, 64'(irq_req));
			if (t >= 2) begin
				gates(tbl[t] & 4'hE);
				cyc(1);
				chk("irq_req no gs", 64'h0, 64'(irq_req));
			end
			gates(tbl[t]);
			cyc(1);
			chk("irq_req on", 64'(5'h01 << t), 64'(irq_req));
			clr(t);
			chk("pending clr", 64'h0, 64'(pending));
		end
		$display("test types done");
	endtask : t_types

	task automatic t_filter();
		gates(4'hF);
		inject(TT_MSG, msg(5, 8'h5A));
		inject(TT_MSG, msg(31, 8'h5A));
		inject(TT_MSG, msg(0, 8'h5B));
		inject(TT_WRITE, msg(0, 8'h5A));
		inject(TT_READ, msg(1, 8'h5A));
		chk("filtered", 64'h0, 64'(pending));
		inject(TT_MSG, msg(1, 8'h5A) | 64'hFFFF_FFFF_0000_0000);
		chk("accepted", 64'h2, 64'(pending));
		clr(1);
		$display("test filter done");
	endtask : t_filter

	task automatic t_repeat();
		gates(4'h0);
		inject(TT_MSG, msg(3, 8'h5A));
		inject(TT_MSG, msg(3, 8'h5A));
		chk("pending twice", 64'h8, 64'(pending));
		clr(3);
		cyc(1);
		chk("pending once clr", 64'h0, 64'(pending));
		$display("test repeat done");
	endtask : t_repeat

	task automatic t_barrier();
		lat = 4'h1;
		stores_drained = 1'b0;
		barrier_req = 1'b1;
		send_operand = msg(4, 8'h5A);
		send_valid = 1'b1;
		cyc(1);
		barrier_req = 1'b0;
		send_valid = 1'b0;
		chk("send taken", 64'h0, 64'(send_ready));
		cyc(6);
		chk("tx held", 64'h0, 64'(tx_valid));
		stores_drained = 1'b1;
		cyc(1);
		chk("tx after drain", 64'h1, 64'(tx_valid));
		wait_pend(4);
		chk("pending mc", 64'h10, 64'(pending));
		clr(4);
		$display("test barrier done");
	endtask : t_barrier

	// ----------------------------------------------------------------
	// Sequence and verdict
	// ----------------------------------------------------------------
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done

	initial begin
		{send_valid, barrier_req, clear_valid, inj_valid} = 4'h0;
		stores_drained = 1'b1;
		gates(4'h0);
		{send_operand, clear_operand, inj_data} = '0;
		inj_ttype = TT_NONE;
		irq_taken = 5'h00;
		lat = 4'h0;
		repeat (6) @(negedge ref_clk);
		resetn = 1'b1;
		cyc(2);
		chk("reset pending", 64'h0, 64'(pending));
		chk("reset tx_ttype", 64'(TT_NONE), 64'(tx_ttype));
		t_send();
		t_types();
		t_filter();
		t_repeat();
		t_barrier();
		test_done();
	end

	initial begin
		#(40 * 20000);
		fails++;
		$display("ERROR watchdog expected finish seen hang");
		test_done();
	end
endmodule : doorbell_message_unit_tb

`default_nettype wire
